// >>> logic/fsp_pkg.sv
/*
 * Shared constants for the flash self-program controller: register indices,
 * control bit positions, key values, timing and state encodings.
 * Assumes a single 40 MHz system clock and an 8-bit register port.
 */
`default_nettype none
package fsp_pkg;
    // ====================================================================
    // geometry
    localparam int ADDR_W = 15;
    localparam int DATA_W = 14;
    localparam int ROW_WORDS = 32;
    localparam int IDX_W = 5;
    localparam int REG_AW = 3;
    localparam logic [DATA_W-1:0] BLANK_WORD = 14'h3FFF;
    // ====================================================================
    // register indices on the plain port
    localparam logic [REG_AW-1:0] REG_ADDR_LOW = 3'h0;
    localparam logic [REG_AW-1:0] REG_ADDR_HIGH = 3'h1;
    localparam logic [REG_AW-1:0] REG_DATA_LOW = 3'h2;
    localparam logic [REG_AW-1:0] REG_DATA_HIGH = 3'h3;
    localparam logic [REG_AW-1:0] REG_CONTROL = 3'h4;
    localparam logic [REG_AW-1:0] REG_KEY = 3'h5;
    // ====================================================================
    // control register bit positions
    localparam int CTL_RD = 0;
    localparam int CTL_WR = 1;
    localparam int CTL_GATE = 2;
    localparam int CTL_INTERRUPTED_PROGRAM_FLAG = 3;
    localparam int CTL_ERASE = 4;
    localparam int CTL_LATCH_ONLY_SELECT = 5;
    localparam int CTL_CONFIG_SPACE_SELECT = 6;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    // ====================================================================
    // timing
    localparam int CLK_MHZ = 40;
    localparam int PROG_TIME_US = 2000;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    // ====================================================================
    // self program guard encodings and protected limits
    localparam logic [1:0] GUARD_ALL = 2'h0;
    localparam logic [1:0] GUARD_HALF = 2'h1;
    localparam logic [1:0] GUARD_LOW = 2'h2;
    localparam logic [1:0] GUARD_NONE = 2'h3;
    localparam logic [ADDR_W-1:0] GUARD_LOW_LIMIT = 15'h0200;
    localparam logic [ADDR_W-1:0] GUARD_HALF_LIMIT = 15'h4000;
    // ====================================================================
    // state encodings
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_RD_WAIT = 7'h02,
        ST_RD_CAP = 7'h04,
        ST_NOP_A = 7'h08,
        ST_NOP_B = 7'h10,
        ST_STREAM = 7'h20,
        ST_BUSY = 7'h40
    } fsp_state_t;
    typedef enum logic [2:0] {
        K_IDLE = 3'h1,
        K_GOT_FIRST = 3'h2,
        K_ARMED = 3'h4
    } fsp_key_t;
endpackage : fsp_pkg
`default_nettype wire

// >>> logic/fsp_ctrl.sv
/*
 * Flash self-program controller: address/data register pairs, control
 * register, keyed unlock, 32 write latches, row erase and row program
 * with processor stall, code and write protection.
 * Assumes a flash array on the same clock returning read data one cycle
 * after fl_rd_o, and a processor that honours cpu_nop_o and cpu_stall_o.
 */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: 14-bit data pair, 15-bit address pair
// R2: high register holds address MSB, low LSB
// R3: read and program bits set-only, hardware clears
// R4: erase/program need enable gate, cleared at power-up
// R5: reset during program sets interrupted flag
// R6: key register reads as zero
// R7: 55h, AAh, then program bit starts operations
// R8: program bit forces two no-operation slots
// R9: erase/program stall processor about 2 ms
// R10: latch load forces nops, no stall
// R11: software loads address, clears config select, reads
// R12: fetch in second slot, data next cycle
// R13: software places two nops after read
// R14: data pair holds until read or write
// R15: rows of 32 words, 32 latches
// R16: latches filled only through data pair
// R17: on-chip timer times erase and program
// R18: readout lock blocks external programmer only
// R19: lock removed only by bulk erase
// R20: guard field blocks self-program over region
// R21: software disables interrupts around unlock
// R22: erase select erases row of address
// R23: latch-only select loads latch, else program row
// R24: upper bits pick row, low five latch
// R25: latches blank after any program or erase
// R26: wrong key write abandons unlock sequence
module fsp_ctrl #(
    parameter int PROG_CYCLES = fsp_pkg::PROG_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic cpu_reset_i,
    input wire logic [fsp_pkg::REG_AW-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    output logic cpu_nop_o,
    output logic cpu_stall_o,
    output logic fl_rd_o,
    output logic fl_erase_o,
    output logic fl_prog_o,
    output logic fl_cfg_o,
    output logic [fsp_pkg::ADDR_W-1:0] fl_addr_o,
    output logic [fsp_pkg::DATA_W-1:0] fl_wdata_o,
    input wire logic [fsp_pkg::DATA_W-1:0] fl_rdata_i,
    input wire logic readout_lock_n_i,
    input wire logic [1:0] self_program_guard_field_i,
    input wire logic bulk_erase_i,
    output logic ext_access_block_o
);
    localparam int CNT_W = $clog2(PROG_CYCLES + 1);

    typedef struct packed {
        fsp_pkg::fsp_state_t st;
        fsp_pkg::fsp_key_t key;
        logic [fsp_pkg::ADDR_W-1:0] adr;
        logic [fsp_pkg::DATA_W-1:0] dat;
        logic rd;
        logic wr;
        logic gate;
        logic interrupted_program_flag;
        logic erase;
        logic latch_only_select;
        logic config_space_select;
        logic [fsp_pkg::ROW_WORDS-1:0][fsp_pkg::DATA_W-1:0] lat;
        logic [fsp_pkg::IDX_W-1:0] idx;
        logic [CNT_W-1:0] cnt;
        logic nop;
        logic stall;
        logic fl_rd;
        logic fl_erase;
        logic fl_prog;
        logic [fsp_pkg::ADDR_W-1:0] fl_addr;
        logic [fsp_pkg::DATA_W-1:0] fl_wdata;
        logic [7:0] rdata;
        logic cp_s1;
        logic cp_s2;
        logic [1:0] grd_s1;
        logic [1:0] grd_s2;
        logic blk_s1;
        logic blk_s2;
        logic lock;
    } fsp_regs_t;

    fsp_regs_t q;
    fsp_regs_t d;

    // ====================================================================
    // helpers
    function automatic logic guard_ok(input logic [fsp_pkg::ADDR_W-1:0] a,
                                      input logic [1:0] g);
        logic ok;
        ok = 1'b1;
        case (g)
            fsp_pkg::GUARD_ALL: ok = 1'b0;
            fsp_pkg::GUARD_HALF: ok = (a >= fsp_pkg::GUARD_HALF_LIMIT);
            fsp_pkg::GUARD_LOW: ok = (a >= fsp_pkg::GUARD_LOW_LIMIT);
            default: ok = 1'b1;
        endcase
        return ok;
    endfunction : guard_ok

    function automatic logic [fsp_pkg::ADDR_W-1:0] row_word(
            input logic [fsp_pkg::ADDR_W-1:0] a, input logic [fsp_pkg::IDX_W-1:0] i);
        return {a[fsp_pkg::ADDR_W-1:fsp_pkg::IDX_W], i};
    endfunction : row_word

    // ====================================================================
    // next state
    always_comb begin
        d = q;
        d.fl_rd = 1'b0;
        d.fl_erase = 1'b0;
        d.fl_prog = 1'b0;
        d.rdata = 8'h00;
        // pin inputs pass two flops before use
        d.cp_s1 = readout_lock_n_i;
        d.cp_s2 = q.cp_s1;
        d.grd_s1 = self_program_guard_field_i;
        d.grd_s2 = q.grd_s1;
        d.blk_s1 = bulk_erase_i;
        d.blk_s2 = q.blk_s1;
        // lock only falls on bulk erase; otherwise a low bit sets it
        d.lock = q.blk_s2 ? 1'b0 : (q.lock | ~q.cp_s2); // R18 R19

        if (reg_re_i) begin
            case (reg_addr_i)
                fsp_pkg::REG_ADDR_LOW: d.rdata = q.adr[7:0]; // R1 R2
                fsp_pkg::REG_ADDR_HIGH: d.rdata = {1'b0, q.adr[14:8]}; // R2
                fsp_pkg::REG_DATA_LOW: d.rdata = q.dat[7:0]; // R1
                fsp_pkg::REG_DATA_HIGH: d.rdata = {2'b00, q.dat[13:8]};
                fsp_pkg::REG_CONTROL: d.rdata = {1'b0, q.config_space_select, q.latch_only_select, q.erase,
                                                 q.interrupted_program_flag, q.gate, q.wr, q.rd};
                default: d.rdata = 8'h00; // R6
            endcase
        end

        if (reg_we_i) begin
            case (reg_addr_i)
                fsp_pkg::REG_ADDR_LOW: d.adr[7:0] = reg_wdata_i;
                fsp_pkg::REG_ADDR_HIGH: d.adr[14:8] = reg_wdata_i[6:0];
                fsp_pkg::REG_DATA_LOW: d.dat[7:0] = reg_wdata_i; // R14 R16
                fsp_pkg::REG_DATA_HIGH: d.dat[13:8] = reg_wdata_i[5:0];
                fsp_pkg::REG_KEY: begin
                    // any unexpected key value drops back to the start
                    if (q.key == fsp_pkg::K_IDLE && reg_wdata_i == fsp_pkg::KEY_FIRST) begin
                        d.key = fsp_pkg::K_GOT_FIRST; // R7
                    end else if (q.key == fsp_pkg::K_GOT_FIRST
                                 && reg_wdata_i == fsp_pkg::KEY_SECOND) begin
                        d.key = fsp_pkg::K_ARMED; // R7
                    end else begin
                        d.key = fsp_pkg::K_IDLE; // R26
                    end
                end
                fsp_pkg::REG_CONTROL: begin
                    d.gate = reg_wdata_i[fsp_pkg::CTL_GATE];
                    d.interrupted_program_flag = reg_wdata_i[fsp_pkg::CTL_INTERRUPTED_PROGRAM_FLAG];
                    d.erase = reg_wdata_i[fsp_pkg::CTL_ERASE];
                    d.latch_only_select = reg_wdata_i[fsp_pkg::CTL_LATCH_ONLY_SELECT];
                    d.config_space_select = reg_wdata_i[fsp_pkg::CTL_CONFIG_SPACE_SELECT];
                    if (reg_wdata_i[fsp_pkg::CTL_WR]) begin
                        d.key = fsp_pkg::K_IDLE; // R26
                    end
                    // starts accepted only when idle; writes of zero never clear
                    if (q.st == fsp_pkg::ST_IDLE) begin
                        if (reg_wdata_i[fsp_pkg::CTL_WR] && q.key == fsp_pkg::K_ARMED
                            && reg_wdata_i[fsp_pkg::CTL_GATE]
                            && (q.config_space_select || guard_ok(q.adr, q.grd_s2))) begin // R4 R7 R20
                            d.wr = 1'b1; // R3
                            d.nop = 1'b1; // R8
                            d.st = fsp_pkg::ST_NOP_A;
                        end else if (reg_wdata_i[fsp_pkg::CTL_RD]) begin
                            d.rd = 1'b1; // R3
                            d.fl_rd = 1'b1;
                            d.fl_addr = q.adr;
                            d.st = fsp_pkg::ST_RD_WAIT;
                        end
                    end
                end
                default: ;
            endcase
        end

        case (q.st)
            fsp_pkg::ST_IDLE: ;
            fsp_pkg::ST_RD_WAIT: begin
                // second slot after the read is the fetch slot
                d.nop = 1'b1; // R12
                d.st = fsp_pkg::ST_RD_CAP;
            end
            fsp_pkg::ST_RD_CAP: begin
                d.nop = 1'b0;
                d.dat = fl_rdata_i; // R12 R14
                d.rd = 1'b0; // R3
                d.st = fsp_pkg::ST_IDLE;
            end
            fsp_pkg::ST_NOP_A: d.st = fsp_pkg::ST_NOP_B; // R8
            fsp_pkg::ST_NOP_B: begin
                d.nop = 1'b0;
                d.cnt = '0;
                if (q.erase) begin
                    d.fl_erase = 1'b1; // R22
                    d.fl_addr = row_word(q.adr, '0);
                    d.stall = 1'b1; // R9
                    d.st = fsp_pkg::ST_BUSY;
                end else begin
                    d.lat[q.adr[fsp_pkg::IDX_W-1:0]] = q.dat; // R16 R24
                    if (q.latch_only_select) begin
                        d.wr = 1'b0; // R10 R23
                        d.st = fsp_pkg::ST_IDLE;
                    end else begin
                        d.idx = '0;
                        d.stall = 1'b1; // R9 R23
                        d.st = fsp_pkg::ST_STREAM;
                    end
                end
            end
            fsp_pkg::ST_STREAM: begin
                // one latch per cycle; never leaves the row
                d.fl_prog = 1'b1; // R15 R24
                d.fl_addr = row_word(q.adr, q.idx);
                d.fl_wdata = q.lat[q.idx];
                d.idx = q.idx + 1'b1;
                if (q.idx == fsp_pkg::IDX_W'(fsp_pkg::ROW_WORDS - 1)) begin
                    d.st = fsp_pkg::ST_BUSY;
                end
            end
            fsp_pkg::ST_BUSY: begin
                d.cnt = q.cnt + 1'b1; // R17
                if (q.cnt == CNT_W'(PROG_CYCLES - 1)) begin
                    d.lat = {fsp_pkg::ROW_WORDS{fsp_pkg::BLANK_WORD}}; // R25
                    d.wr = 1'b0; // R3
                    d.stall = 1'b0; // R9
                    d.st = fsp_pkg::ST_IDLE;
                end
            end
            default: d.st = fsp_pkg::ST_IDLE;
        endcase

        // core reset: abandon work, remember an interrupted program
        if (cpu_reset_i) begin
            // hardware set wins over a software clear in the same cycle
            d.interrupted_program_flag = d.interrupted_program_flag | q.wr; // R5
            d.st = fsp_pkg::ST_IDLE;
            d.key = fsp_pkg::K_IDLE;
            d.rd = 1'b0;
            d.wr = 1'b0;
            d.gate = 1'b0;
            d.nop = 1'b0;
            d.stall = 1'b0;
            d.fl_erase = 1'b0;
            d.fl_prog = 1'b0;
            d.fl_rd = 1'b0;
            d.lat = {fsp_pkg::ROW_WORDS{fsp_pkg::BLANK_WORD}};
        end
    end

    // ====================================================================
    // state register
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0; // R4
            q.st <= fsp_pkg::ST_IDLE;
            q.key <= fsp_pkg::K_IDLE;
            q.lat <= {fsp_pkg::ROW_WORDS{fsp_pkg::BLANK_WORD}};
            q.cp_s1 <= 1'b1;
            q.cp_s2 <= 1'b1;
            q.grd_s1 <= fsp_pkg::GUARD_NONE;
            q.grd_s2 <= fsp_pkg::GUARD_NONE;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata_o = q.rdata;
    assign cpu_nop_o = q.nop;
    assign cpu_stall_o = q.stall;
    assign fl_rd_o = q.fl_rd;
    assign fl_erase_o = q.fl_erase;
    assign fl_prog_o = q.fl_prog;
    assign fl_cfg_o = q.config_space_select;
    assign fl_addr_o = q.fl_addr;
    assign fl_wdata_o = q.fl_wdata;
    assign ext_access_block_o = q.lock;

    // ====================================================================
    // checks
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);

    key_read_zero_a: assert property ( // R6
        reg_re_i && reg_addr_i == fsp_pkg::REG_KEY |=> reg_rdata_o == 8'h00)
        else $error("key register read not zero");
    start_gate_a: assert property ( // R4
        $rose(q.wr) |-> q.gate && $past(q.key) == fsp_pkg::K_ARMED)
        else $error("program started without gate or key");
    two_nops_a: assert property ( // R8
        $rose(q.wr) |-> cpu_nop_o [*2] ##1 !cpu_nop_o)
        else $error("program start did not force two nops");
    read_fetch_a: assert property ( // R12
        $rose(q.rd) |-> fl_rd_o ##1 (cpu_nop_o && !fl_rd_o) ##1 !q.rd)
        else $error("read fetch timing wrong");
    latch_no_stall_a: assert property ( // R10
        $rose(q.wr) && q.latch_only_select && !q.erase && !cpu_reset_i |-> !cpu_stall_o [*3] ##1 !q.wr)
        else $error("latch load stalled or did not finish");
    stall_end_a: assert property ( // R9
        $fell(cpu_stall_o) && !$past(cpu_reset_i) |-> !q.wr
            && q.lat[0] == fsp_pkg::BLANK_WORD)
        else $error("stall ended without completion cleanup");
    interrupted_program_flag_set_a: assert property ( // R5
        cpu_reset_i && q.wr |=> q.interrupted_program_flag)
        else $error("interrupted program not flagged");
    data_hold_a: assert property ( // R14
        q.st != fsp_pkg::ST_RD_CAP && !(reg_we_i && (reg_addr_i == fsp_pkg::REG_DATA_LOW
            || reg_addr_i == fsp_pkg::REG_DATA_HIGH)) |=> $stable(q.dat))
        else $error("data pair changed without read or write");
    key_abandon_a: assert property ( // R26
        reg_we_i && reg_addr_i == fsp_pkg::REG_KEY && q.key == fsp_pkg::K_GOT_FIRST
            && reg_wdata_i != fsp_pkg::KEY_SECOND |=> q.key == fsp_pkg::K_IDLE)
        else $error("bad key did not abandon sequence");
endmodule : fsp_ctrl
`default_nettype wire

// >>> tb/fsp_flash_model.sv
/*
 * Behavioural flash array standing behind the self-program controller.
 * Assumes the controller's clock, read data due one cycle after a read
 * pulse, and only the lowest 1K words ever addressed by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_model (
    input wire logic core_clk_i,
    input wire logic rd_i,
    input wire logic erase_i,
    input wire logic prog_i,
    input wire logic [14:0] addr_i,
    input wire logic [13:0] wdata_i,
    output logic [13:0] rdata_o
);
    // ====================================================================
    // storage, trimmed to 1K words to keep the run light
    logic [13:0] mem [0:1023];
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = 14'(i * 3) ^ 14'h1A2B;
        end
        rdata_o = 14'h0000;
    end
    // ====================================================================
    // access
    always @(posedge core_clk_i) begin
        // outside the answer cycle the bus flips, so stale data never passes
        rdata_o <= rd_i ? mem[addr_i[9:0]] : ~rdata_o;
        if (erase_i) begin
            for (int i = 0; i < 32; i++) begin
                mem[{addr_i[9:5], 5'(i)}] <= 14'h3FFF;
            end
        end
        if (prog_i) begin
            mem[addr_i[9:0]] <= wdata_i;
        end
    end
endmodule : fsp_flash_model
`default_nettype wire

// >>> tb/fsp_ctrl_tb.sv
/*
 * Self-checking bench for the flash self-program controller.
 * Assumes a flash model on the far side and a shortened program time.
 */
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl_tb;
    localparam int PC = 20;
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic cpu_reset_i = 1'b0;
    logic [2:0] reg_addr_i = 3'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_we_i = 1'b0;
    logic reg_re_i = 1'b0;
    logic readout_lock_n_i = 1'b1;
    logic [1:0] guard = fsp_pkg::GUARD_LOW;
    logic bulk_erase_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic cpu_nop_o, cpu_stall_o, fl_rd_o, fl_erase_o, fl_prog_o, ext_access_block_o, fl_cfg_o;
    logic [14:0] fl_addr_o;
    logic [13:0] fl_wdata_o, fl_rdata_i, hold_w;
    logic [13:0] wd [0:2];
    logic [4:0] idx [0:2] = '{5'h00, 5'h05, 5'h1F};
    logic [7:0] exp_q [$];
    logic [7:0] msk_q [$];
    logic re_q = 1'b0;
    int error_cnt = 0;
    int cmp_count = 0;
    int seed = 25869;
    always #12.5 core_clk_i = ~core_clk_i;
    fsp_ctrl #(.PROG_CYCLES(PC)) fsp_ctrl_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .cpu_reset_i(cpu_reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
        .cpu_nop_o(cpu_nop_o), .cpu_stall_o(cpu_stall_o), .fl_rd_o(fl_rd_o),
        .fl_erase_o(fl_erase_o), .fl_prog_o(fl_prog_o), .fl_cfg_o(fl_cfg_o),
        .fl_addr_o(fl_addr_o),
        .fl_wdata_o(fl_wdata_o), .fl_rdata_i(fl_rdata_i), .readout_lock_n_i(readout_lock_n_i),
        .self_program_guard_field_i(guard), .bulk_erase_i(bulk_erase_i),
        .ext_access_block_o(ext_access_block_o));
    fsp_flash_model fsp_flash_model_i (.core_clk_i(core_clk_i), .rd_i(fl_rd_o),
        .erase_i(fl_erase_o), .prog_i(fl_prog_o), .addr_i(fl_addr_o),
        .wdata_i(fl_wdata_o), .rdata_o(fl_rdata_i));
    // ====================================================================
    // checking
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // read data stand only in the cycle after the strobe
    always @(posedge core_clk_i) begin
        re_q <= reg_re_i;
        if (re_q) begin
            chk({8'h00, reg_rdata_o & msk_q[0]}, {8'h00, exp_q[0]});
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end
    function automatic logic [13:0] init_word(input logic [14:0] a);
        return 14'(int'(a[9:0]) * 3) ^ 14'h1A2B;
    endfunction : init_word
    // ====================================================================
    // register port
    task automatic idle(input int n);
        repeat (n) begin
            reg_we_i <= 1'b0;
            reg_re_i <= 1'b0;
            @(posedge core_clk_i);
        end
    endtask : idle
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= 1'b1;
        reg_re_i <= 1'b0;
        @(posedge core_clk_i);
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        reg_we_i <= 1'b0;
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge core_clk_i);
    endtask : rd
    task automatic set_addr(input logic [14:0] a);
        wr(fsp_pkg::REG_ADDR_LOW, a[7:0]);
        wr(fsp_pkg::REG_ADDR_HIGH, {1'b0, a[14:8]});
    endtask : set_addr
    task automatic flash_read(input logic [14:0] a, input logic [13:0] e);
        set_addr(a);
        wr(fsp_pkg::REG_CONTROL, 8'h01);
        idle(1);
        @(negedge core_clk_i);
        chk(cpu_nop_o, 1'b1);
        chk(fl_cfg_o, 1'b0);
        @(posedge core_clk_i);
        rd(fsp_pkg::REG_DATA_LOW, e[7:0], 8'hFF);
        rd(fsp_pkg::REG_DATA_HIGH, {2'b00, e[13:8]}, 8'hFF);
        rd(fsp_pkg::REG_CONTROL, 8'h00, 8'h01);
        idle(1);
    endtask : flash_read
    // keyed operation; n_exp is the stall length in cycles
    task automatic op(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] ctl,
                      input logic acc, input int n_exp);
        int n;
        n = 0;
        wr(fsp_pkg::REG_KEY, k1);
        wr(fsp_pkg::REG_KEY, k2);
        wr(fsp_pkg::REG_CONTROL, ctl);
        idle(1);
        @(negedge core_clk_i);
        chk(cpu_nop_o, acc);
        @(negedge core_clk_i);
        chk(cpu_nop_o, 1'b0);
        while (cpu_stall_o === 1'b1 && n < 2000) begin
            n++;
            @(negedge core_clk_i);
        end
        chk(16'(n), 16'(n_exp));
        @(posedge core_clk_i);
    endtask : op
    // ====================================================================
    // closing
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    initial begin
        #(25 * 8000);
        error_cnt++;
        summarize();
    end
    // ====================================================================
    // scenarios
    initial begin
        repeat (3) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        idle(2);
        rd(fsp_pkg::REG_CONTROL, 8'h00, 8'hFF);
        wr(fsp_pkg::REG_KEY, 8'h55);
        rd(fsp_pkg::REG_KEY, 8'h00, 8'hFF);
        rd(3'h6, 8'h00, 8'hFF);
        rd(3'h7, 8'h00, 8'hFF);
        // drop the half-open key so later refusals are down to their own cause
        wr(fsp_pkg::REG_KEY, 8'h00);
        idle(1);
        repeat (3) begin
            hold_w = 14'($random(seed)) & 14'h03FF;
            flash_read(15'(hold_w), init_word(15'(hold_w)));
        end
        wr(fsp_pkg::REG_DATA_LOW, 8'h5A);
        rd(fsp_pkg::REG_DATA_LOW, 8'h5A, 8'hFF);
        hold_w = init_word(15'(hold_w));
        rd(fsp_pkg::REG_DATA_HIGH, {2'b00, hold_w[13:8]}, 8'hFF);
        set_addr(15'h0060);
        op(8'h55, 8'hAA, 8'h16, 1'b0, 0);
        flash_read(15'h0060, init_word(15'h0060));
        set_addr(15'h0260);
        op(8'h55, 8'hAA, 8'h12, 1'b0, 0);
        op(8'h55, 8'h56, 8'h16, 1'b0, 0);
        op(8'hAA, 8'h55, 8'h16, 1'b0, 0);
        op(8'h55, 8'hAA, 8'h16, 1'b1, PC);
        flash_read(15'h0265, 14'h3FFF);
        for (int i = 0; i < 3; i++) begin
            wd[i] = 14'($random(seed));
            set_addr({10'h013, idx[i]});
            wr(fsp_pkg::REG_DATA_LOW, wd[i][7:0]);
            wr(fsp_pkg::REG_DATA_HIGH, {2'b00, wd[i][13:8]});
            op(8'h55, 8'hAA, (i < 2) ? 8'h26 : 8'h06, 1'b1, (i < 2) ? 0 : 32 + PC);
        end
        rd(fsp_pkg::REG_CONTROL, 8'h04, 8'hFF);
        idle(1);
        for (int i = 0; i < 3; i++) begin
            flash_read({10'h013, idx[i]}, wd[i]);
        end
        flash_read(15'h0261, 14'h3FFF);
        op(8'h55, 8'hAA, 8'h16, 1'b1, PC);
        wr(fsp_pkg::REG_KEY, 8'h55);
        wr(fsp_pkg::REG_KEY, 8'hAA);
        wr(fsp_pkg::REG_CONTROL, 8'h06);
        idle(6);
        cpu_reset_i <= 1'b1;
        idle(1);
        cpu_reset_i <= 1'b0;
        idle(2);
        chk(cpu_stall_o, 1'b0);
        rd(fsp_pkg::REG_CONTROL, 8'h08, 8'h0F);
        idle(1);
        chk(ext_access_block_o, 1'b0);
        readout_lock_n_i <= 1'b0;
        idle(6);
        chk(ext_access_block_o, 1'b1);
        readout_lock_n_i <= 1'b1;
        idle(6);
        chk(ext_access_block_o, 1'b1);
        bulk_erase_i <= 1'b1;
        idle(6);
        chk(ext_access_block_o, 1'b0);
        bulk_erase_i <= 1'b0;
        wr(fsp_pkg::REG_CONTROL, 8'h40);
        idle(1);
        chk(fl_cfg_o, 1'b1);
        rd(fsp_pkg::REG_CONTROL, 8'h40, 8'hFF);
        idle(2);
        summarize();
    end
endmodule : fsp_ctrl_tb
`default_nettype wire
